// file: src/stpc_pkg.sv
// Constants and carrier types for the self-test and driver pattern control block.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 8-bit byte addresses.
// Notes on behaviour
// - An 8-bit read-only count in bits 15:8 of the control register counts errored nibbles during a packet self test.
// - The error count returns to zero when the packet self test is started again, or to one if an error arrives in the restart cycle.
// - The error count sticks at its largest value and never wraps until the next restart.
// - With the continuous bit set the transmitter sends pseudo-random test data with no gap between packets.
// - Continuous mode takes effect only together with the self-test enable held in the PHY control register.
// - The 10 Mb/s driver pattern runs only while the pattern enable bit is one.
// - The gap between data or link-pulse sequences is 15 us when the gap bit is one, else 10 us.
// - Select 00 sends data then end-of-packet form a, 01 data then form b, 10 normal link pulses.
// - Select 11 sends constant Manchester ones, a 10 MHz tone.
// - The jabber function is off while the jabber disable bit is one and on while it is zero.
package stpc_pkg;

  localparam int unsigned CLK_MHZ = 20;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [5:0] IDX_PHY_CONTROL    = 6'h19;
  localparam logic [5:0] IDX_TENMEG_STATUS  = 6'h1A;
  localparam logic [5:0] IDX_PATTERN_CTRL   = 6'h1B;
  localparam logic [7:0] ADDR_PHY_CONTROL   = {IDX_PHY_CONTROL, 2'b00};
  localparam logic [7:0] ADDR_TENMEG_STATUS = {IDX_TENMEG_STATUS, 2'b00};
  localparam logic [7:0] ADDR_PATTERN_CTRL  = {IDX_PATTERN_CTRL, 2'b00};

  // Pattern control fields
  localparam int unsigned ERRCNT_LSB  = 8;
  localparam int unsigned CONT_BIT    = 5;
  localparam int unsigned PATTEN_BIT  = 4;
  localparam int unsigned GAP_BIT     = 2;
  localparam int unsigned PSEL_LSB    = 0;
  localparam logic [7:0]  PATTERN_CTRL_RESET = 8'h00;

  // PHY control fields
  localparam int unsigned PHYCTL_BIST_EN_BIT  = 8;
  localparam int unsigned PHYCTL_SATURATE_BIT = 9;

  // Ten-meg status and control fields
  localparam int unsigned JABBER_DIS_BIT = 0;

  localparam logic [1:0] PSEL_DATA_EOP_A = 2'b00;
  localparam logic [1:0] PSEL_DATA_EOP_B = 2'b01;
  localparam logic [1:0] PSEL_LINK_PULSE = 2'b10;
  localparam logic [1:0] PSEL_TONE       = 2'b11;

  // One clock is one Manchester half-bit at 10 Mb/s
  localparam int unsigned GAP_SHORT_US   = 10;
  localparam int unsigned GAP_LONG_US    = 15;
  localparam logic [8:0]  GAP_SHORT_CYC  = 9'(GAP_SHORT_US * CLK_MHZ);
  localparam logic [8:0]  GAP_LONG_CYC   = 9'(GAP_LONG_US * CLK_MHZ);
  localparam logic [8:0]  DATA_HALF_BITS = 9'h080;
  localparam logic [8:0]  EOP_A_CYC      = 9'h005;
  localparam logic [8:0]  EOP_B_CYC      = 9'h009;
  localparam logic [8:0]  NLP_CYC        = 9'h002;
  localparam logic [8:0]  LFSR_SEED      = 9'h1FF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } stpc_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stpc_axil_rsp_s;

endpackage : stpc_pkg

// file: src/stpc_pattern_gen.sv
// Ten-meg cable-driver test pattern generator.
// Assumes clk_sys is 20 MHz so one cycle is one Manchester half-bit.
`timescale 1ns/100ps
`default_nettype none
module stpc_pattern_gen (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [1:0] select,
  input  wire logic       long_gap,
  output var  logic       tx10_line,
  output var  logic       tx10_drive
);

  typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_EOP, ST_NLP, ST_GAP, ST_TONE} stpc_pat_e;

  stpc_pat_e  state;
  logic [8:0] count;
  logic [8:0] lfsr;
  logic       second_half;
  logic [8:0] gap_len;

  assign gap_len = long_gap ? stpc_pkg::GAP_LONG_CYC : stpc_pkg::GAP_SHORT_CYC;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      count <= 9'h000;
    end else if (!enable) begin
      state <= ST_IDLE;
      count <= 9'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          count <= 9'h000;
          case (select)
            stpc_pkg::PSEL_DATA_EOP_A: state <= ST_DATA;
            stpc_pkg::PSEL_DATA_EOP_B: state <= ST_DATA;
            stpc_pkg::PSEL_LINK_PULSE: state <= ST_NLP;
            default:                   state <= ST_TONE;
          endcase
        end
        ST_DATA: begin
          if (count == stpc_pkg::DATA_HALF_BITS - 9'h001) begin
            state <= ST_EOP;
            count <= 9'h000;
          end else begin
            count <= count + 9'h001;
          end
        end
        ST_EOP: begin
          if ((select == stpc_pkg::PSEL_DATA_EOP_A && count == stpc_pkg::EOP_A_CYC - 9'h001) ||
              (select != stpc_pkg::PSEL_DATA_EOP_A && count == stpc_pkg::EOP_B_CYC - 9'h001)) begin
            state <= ST_GAP;
            count <= 9'h000;
          end else begin
            count <= count + 9'h001;
          end
        end
        ST_NLP: begin
          if (count == stpc_pkg::NLP_CYC - 9'h001) begin
            state <= ST_GAP;
            count <= 9'h000;
          end else begin
            count <= count + 9'h001;
          end
        end
        ST_GAP: begin
          // Select changes take effect at the next sequence
          if (count >= gap_len - 9'h001) begin
            state <= ST_IDLE;
            count <= 9'h000;
          end else begin
            count <= count + 9'h001;
          end
        end
        ST_TONE: begin
          if (select != stpc_pkg::PSEL_TONE) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          count <= 9'h000;
        end
      endcase
    end
  end

  // Half-bit phase and pseudo-random data, one new bit per two cycles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      second_half <= 1'b0;
      lfsr        <= stpc_pkg::LFSR_SEED;
    end else if (state == ST_DATA || state == ST_TONE) begin
      second_half <= ~second_half;
      if (second_half && state == ST_DATA) begin
        lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
    end else begin
      second_half <= 1'b0;
    end
  end

  // Manchester: a one is low then high; form a ends high, form b ends low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx10_line  <= 1'b0;
      tx10_drive <= 1'b0;
    end else begin
      case (state)
        ST_DATA: begin
          tx10_line  <= second_half ? lfsr[0] : ~lfsr[0];
          tx10_drive <= 1'b1;
        end
        ST_EOP: begin
          tx10_line  <= (select == stpc_pkg::PSEL_DATA_EOP_A);
          tx10_drive <= 1'b1;
        end
        ST_NLP: begin
          tx10_line  <= 1'b1;
          tx10_drive <= 1'b1;
        end
        ST_TONE: begin
          tx10_line  <= second_half;
          tx10_drive <= 1'b1;
        end
        default: begin
          tx10_line  <= 1'b0;
          tx10_drive <= 1'b0;
        end
      endcase
    end
  end

endmodule : stpc_pattern_gen
`default_nettype wire

// file: src/stpc_top.sv
// Self-test error counter, continuous-mode control and pattern control registers.
// Assumes an AXI4-Lite master on clk_sys and a receive checker giving one-cycle error pulses.
`timescale 1ns/100ps
`default_nettype none
module stpc_top (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire stpc_pkg::stpc_axil_req_s bus_req,
  output var  stpc_pkg::stpc_axil_rsp_s bus_rsp,
  input  wire logic                    rx_nibble_error,
  output var  logic                    bist_enable,
  output var  logic                    bist_restart,
  output var  logic                    continuous_tx,
  output var  logic                    jabber_enable,
  output var  logic                    tx10_line,
  output var  logic                    tx10_drive
);

  logic [7:0]  pattern_ctrl;
  logic [7:0]  error_count;
  logic        bist_en_bit;
  logic        jabber_dis;
  logic        wr_take;
  logic        rd_take;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [31:0] next_rdata;
  logic        wr_hit_pattern;
  logic        wr_hit_phy;
  logic        wr_hit_tenmeg;
  logic        saturated;

  // Both write channels are taken together, one write outstanding at most
  assign wr_take = bus_req.awvalid & bus_req.wvalid & ~bvalid;
  assign rd_take = bus_req.arvalid & ~rvalid;

  assign wr_hit_pattern = wr_take && bus_req.awaddr == stpc_pkg::ADDR_PATTERN_CTRL;
  assign wr_hit_phy     = wr_take && bus_req.awaddr == stpc_pkg::ADDR_PHY_CONTROL;
  assign wr_hit_tenmeg  = wr_take && bus_req.awaddr == stpc_pkg::ADDR_TENMEG_STATUS;

  // One process drives the whole response struct so it has a single driver
  always_comb begin
    bus_rsp         = '0;
    bus_rsp.awready = wr_take;
    bus_rsp.wready  = wr_take;
    bus_rsp.bvalid  = bvalid;
    bus_rsp.bresp   = bresp;
    bus_rsp.arready = rd_take;
    bus_rsp.rvalid  = rvalid;
    bus_rsp.rdata   = rdata;
    bus_rsp.rresp   = rresp;
  end

  assign saturated = (error_count == 8'hFF);

  // Write response channel
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= stpc_pkg::RESP_OKAY;
    end else if (wr_take) begin
      bvalid <= 1'b1;
      bresp  <= (wr_hit_pattern | wr_hit_phy | wr_hit_tenmeg) ?
                stpc_pkg::RESP_OKAY : stpc_pkg::RESP_SLVERR;
    end else if (bus_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // Pattern control low byte; only byte lane 0 carries writable bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pattern_ctrl <= stpc_pkg::PATTERN_CTRL_RESET;
    end else if (wr_hit_pattern && bus_req.wstrb[0]) begin
      pattern_ctrl <= bus_req.wdata[7:0];
    end
  end

  // Self-test enable; any write with byte lane 1 strobed and the bit set restarts the test
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bist_en_bit  <= 1'b0;
      bist_restart <= 1'b0;
    end else begin
      bist_restart <= 1'b0;
      if (wr_hit_phy && bus_req.wstrb[1]) begin
        bist_en_bit  <= bus_req.wdata[stpc_pkg::PHYCTL_BIST_EN_BIT];
        bist_restart <= bus_req.wdata[stpc_pkg::PHYCTL_BIST_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      jabber_dis <= 1'b0;
    end else if (wr_hit_tenmeg && bus_req.wstrb[0]) begin
      jabber_dis <= bus_req.wdata[stpc_pkg::JABBER_DIS_BIT];
    end
  end

  // Error nibble counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      error_count <= 8'h00;
    end else if (bist_restart) begin
      // clear on restart; an error in the same cycle still counts
      error_count <= {7'h00, rx_nibble_error & bist_en_bit};
    end else if (bist_en_bit && rx_nibble_error && !saturated) begin
      // count errored nibbles, stick at maximum
      error_count <= error_count + 8'h01;
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (bus_req.araddr)
      stpc_pkg::ADDR_PATTERN_CTRL: begin
        next_rdata[15:0] = {error_count, pattern_ctrl};
      end
      stpc_pkg::ADDR_PHY_CONTROL: begin
        next_rdata[stpc_pkg::PHYCTL_BIST_EN_BIT]  = bist_en_bit;
        next_rdata[stpc_pkg::PHYCTL_SATURATE_BIT] = saturated;
      end
      stpc_pkg::ADDR_TENMEG_STATUS: begin
        next_rdata[stpc_pkg::JABBER_DIS_BIT] = jabber_dis;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= stpc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= (bus_req.araddr == stpc_pkg::ADDR_PATTERN_CTRL ||
                 bus_req.araddr == stpc_pkg::ADDR_PHY_CONTROL ||
                 bus_req.araddr == stpc_pkg::ADDR_TENMEG_STATUS) ?
                stpc_pkg::RESP_OKAY : stpc_pkg::RESP_SLVERR;
    end else if (bus_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control outputs registered so they settle with the register state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bist_enable   <= 1'b0;
      continuous_tx <= 1'b0;
      jabber_enable <= 1'b1;
    end else begin
      bist_enable   <= bist_en_bit;
      // gapless data, only with self-test enable
      // jabber must already be off at 10 Mb/s; not enforced here
      continuous_tx <= pattern_ctrl[stpc_pkg::CONT_BIT] & bist_en_bit;
      jabber_enable <= ~jabber_dis;
    end
  end

  stpc_pattern_gen u_pattern_gen (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .enable     (pattern_ctrl[stpc_pkg::PATTEN_BIT]),
    .select     (pattern_ctrl[stpc_pkg::PSEL_LSB +: 2]),
    .long_gap   (pattern_ctrl[stpc_pkg::GAP_BIT]),
    .tx10_line  (tx10_line),
    .tx10_drive (tx10_drive)
  );

endmodule : stpc_top
`default_nettype wire

// file: dv/stpc_top_asserts.sv
// Checker for stpc_top: bus answers, restart pulse, derived outputs and pattern gating.
// Assumes it sees only the top ports; control bits are shadowed from taken writes.
`timescale 1ns/100ps
`default_nettype none
module stpc_top_asserts (
  input wire logic                     clk_sys,
  input wire logic                     reset,
  input wire stpc_pkg::stpc_axil_req_s bus_req,
  input wire stpc_pkg::stpc_axil_rsp_s bus_rsp,
  input wire logic                     rx_nibble_error,
  input wire logic                     bist_enable,
  input wire logic                     bist_restart,
  input wire logic                     continuous_tx,
  input wire logic                     jabber_enable,
  input wire logic                     tx10_line,
  input wire logic                     tx10_drive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic       wr_go;
  logic       rst_req;
  logic [7:0] pat;
  logic       bist_bit;
  logic       jab_dis;
  assign wr_go = bus_req.awvalid && bus_req.wvalid && bus_rsp.awready;
  assign rst_req = wr_go && bus_req.awaddr == stpc_pkg::ADDR_PHY_CONTROL && bus_req.wstrb[1]
                   && bus_req.wdata[8];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pat      <= 8'h00;
      bist_bit <= 1'b0;
      jab_dis  <= 1'b0;
    end else if (wr_go) begin
      if (bus_req.wstrb[0] && bus_req.awaddr == stpc_pkg::ADDR_PATTERN_CTRL)
        pat <= bus_req.wdata[7:0];
      if (bus_req.wstrb[1] && bus_req.awaddr == stpc_pkg::ADDR_PHY_CONTROL)
        bist_bit <= bus_req.wdata[8];
      if (bus_req.wstrb[0] && bus_req.awaddr == stpc_pkg::ADDR_TENMEG_STATUS)
        jab_dis <= bus_req.wdata[0];
    end
  end
  a_write_answer:
    assert property (wr_go |=> bus_rsp.bvalid) else $error("write not answered");
  a_read_answer:
    assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
      else $error("read not answered");
  a_ready_pair:
    assert property (bus_rsp.awready |-> bus_req.awvalid && bus_req.wvalid && bus_rsp.wready)
      else $error("write taken without both halves");
  a_read_clears:
    assert property (bus_rsp.rvalid && bus_req.rready |=> !bus_rsp.rvalid)
      else $error("read answer not released");
  a_restart_pulse:
    assert property (bist_restart == $past(rst_req)) else $error("restart pulse wrong");
  a_cont_follow:
    assert property (continuous_tx == $past(pat[5] && bist_bit))
      else $error("continuous output wrong");
  a_jabber_follow:
    assert property (jabber_enable == !$past(jab_dis)) else $error("jabber enable wrong");
  a_enable_follow:
    assert property (bist_enable == $past(bist_bit)) else $error("self-test enable wrong");
  a_pattern_off:
    assert property ((!pat[4])[*3] |-> !tx10_drive) else $error("line driven while disabled");
  a_tone_start:
    assert property ($rose(pat[4]) && pat[1:0] == 2'b11
      |-> ##3 (tx10_drive && tx10_line != $past(tx10_line))[*4]) else $error("no tone");
endmodule : stpc_top_asserts
bind stpc_top stpc_top_asserts u_asserts (.clk_sys(clk_sys), .reset(reset),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .rx_nibble_error(rx_nibble_error),
  .bist_enable(bist_enable), .bist_restart(bist_restart), .continuous_tx(continuous_tx),
  .jabber_enable(jabber_enable), .tx10_line(tx10_line), .tx10_drive(tx10_drive));
`default_nettype wire

// file: dv/stpc_line_model.sv
// Far side: receive checker giving error pulses and a monitor of the driver output.
// Assumes one error burst is requested at a time; run lengths are counted in clocks.
`timescale 1ns/100ps
`default_nettype none
module stpc_line_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       tx10_line,
  input  wire logic       tx10_drive,
  input  wire logic       err_go,
  input  wire logic [8:0] err_num,
  output var  logic       rx_nibble_error,
  output var  logic       err_busy,
  output var  logic [9:0] low_run,
  output var  logic [9:0] high_run,
  output var  logic       end_level,
  output var  logic [7:0] rises
);
  logic [8:0] left;
  logic [9:0] run;
  logic       drv_q;
  logic       line_q;
  assign err_busy = (left != 9'h000) || rx_nibble_error;
  // Back-to-back pulses are the hardest case for the counter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      left            <= 9'h000;
      rx_nibble_error <= 1'b0;
    end else if (err_go) begin
      left <= err_num;
    end else begin
      rx_nibble_error <= left != 9'h000;
      if (left != 9'h000) left <= left - 9'h001;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {drv_q, line_q, end_level} <= 3'h0;
      {run, low_run, high_run}   <= 30'h0000_0000;
      rises                      <= 8'h00;
    end else begin
      drv_q  <= tx10_drive;
      line_q <= tx10_line;
      run    <= (tx10_drive != drv_q) ? 10'h001 : run + 10'h001;
      if (tx10_drive != drv_q && drv_q) begin
        high_run  <= run;
        end_level <= line_q;
      end
      if (tx10_drive != drv_q && !drv_q) begin
        low_run <= run;
        rises   <= rises + 8'h01;
      end
    end
  end
endmodule : stpc_line_model
`default_nettype wire

// file: dv/packet_bist_pattern_control_tb_top.sv
// Bench for stpc_top: AXI4-Lite register tests, error counting and pattern output.
// Assumes the line model measures the driver runs; bready and rready stay high.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module packet_bist_pattern_control_tb_top;
  logic                     clk_sys = 1'b0;
  logic                     reset = 1'b1;
  stpc_pkg::stpc_axil_req_s rq = '{bready: 1'b1, rready: 1'b1, default: '0};
  stpc_pkg::stpc_axil_rsp_s rs;
  logic rx_nibble_error, bist_enable, bist_restart, continuous_tx, jabber_enable;
  logic tx10_line, tx10_drive, err_busy, end_level, l0;
  logic                     err_go = 1'b0;
  logic [8:0]               err_num = 9'h000;
  logic [9:0]               low_run, high_run, gp;
  logic [7:0]               rises, k;
  logic [31:0]              d;
  logic [1:0]               r;
  int                       fails = 0;
  int                       check_count = 0;
  always #25 clk_sys = ~clk_sys;
  stpc_top u_dut (.clk_sys(clk_sys), .reset(reset), .bus_req(rq), .bus_rsp(rs),
    .rx_nibble_error(rx_nibble_error), .bist_enable(bist_enable), .bist_restart(bist_restart),
    .continuous_tx(continuous_tx), .jabber_enable(jabber_enable), .tx10_line(tx10_line),
    .tx10_drive(tx10_drive));
  stpc_line_model u_line (.clk_sys(clk_sys), .reset(reset), .tx10_line(tx10_line),
    .tx10_drive(tx10_drive), .err_go(err_go), .err_num(err_num),
    .rx_nibble_error(rx_nibble_error), .err_busy(err_busy), .low_run(low_run),
    .high_run(high_run), .end_level(end_level), .rises(rises));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Sampled at the falling edge, where handshakes stand settled before the taking edge
  task automatic step(inout int n);
    @(negedge clk_sys);
    n++;
    if (n > 2000) begin
      fails++;
      final_report();
    end
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    int n = 0;
    rq.awvalid <= 1'b1;
    rq.awaddr  <= a;
    rq.wvalid  <= 1'b1;
    rq.wdata   <= v;
    rq.wstrb   <= s;
    do step(n); while (!(rs.awready && rs.wready));
    @(posedge clk_sys);
    rq.awvalid <= 1'b0;
    rq.wvalid  <= 1'b0;
    do step(n); while (!rs.bvalid);
    r = rs.bresp;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n = 0;
    rq.arvalid <= 1'b1;
    rq.araddr  <= a;
    do step(n); while (!rs.arready);
    @(posedge clk_sys);
    rq.arvalid <= 1'b0;
    do step(n); while (!rs.rvalid);
    d = rs.rdata;
    r = rs.rresp;
    @(posedge clk_sys);
  endtask : rd
  task automatic errs(input logic [8:0] v);
    int n = 0;
    err_num <= v;
    err_go  <= 1'b1;
    @(posedge clk_sys);
    err_go <= 1'b0;
    do step(n); while (err_busy);
    @(posedge clk_sys);
    rd(stpc_pkg::ADDR_PATTERN_CTRL);
  endtask : errs
  initial begin
    int n;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK("jabber_enable", 1'b1, jabber_enable)
    rd(stpc_pkg::ADDR_PATTERN_CTRL);
    `CHK("pattern reset", 32'h0000_0000, d)
    rd(8'h70);
    `CHK("unmapped resp", stpc_pkg::RESP_SLVERR, r)
    $display("test reset done");
    wr(stpc_pkg::ADDR_PHY_CONTROL, 32'h0000_0100, 4'h3);
    errs(9'h005);
    `CHK("count", 32'h0000_0500, d)
    wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h0000_FF00, 4'h3);
    rd(stpc_pkg::ADDR_PATTERN_CTRL);
    `CHK("count kept", 32'h0000_0500, d)
    wr(stpc_pkg::ADDR_PHY_CONTROL, 32'h0000_0100, 4'h3);
    errs(9'h000);
    `CHK("count cleared", 32'h0000_0000, d)
    errs(9'h12C);
    `CHK("count stuck", 32'h0000_FF00, d)
    rd(stpc_pkg::ADDR_PHY_CONTROL);
    `CHK("saturated flag", 32'h0000_0300, d)
    $display("test error count done");
    wr(stpc_pkg::ADDR_TENMEG_STATUS, 32'h0000_0001, 4'h1);
    wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h0000_0020, 4'h1);
    @(posedge clk_sys);
    `CHK("jabber off", 1'b0, jabber_enable)
    `CHK("continuous on", 1'b1, continuous_tx)
    wr(stpc_pkg::ADDR_PHY_CONTROL, 32'h0000_0000, 4'h3);
    @(posedge clk_sys);
    `CHK("continuous off", 1'b0, continuous_tx)
    wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h0000_0000, 4'h1);
    $display("test continuous done");
    for (int i = 0; i < 6; i++) begin
      wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h10 | ((i / 3) << 2) | (i % 3), 4'h1);
      k = rises;
      n = 0;
      do step(n); while (8'(rises - k) < 8'h02);
      gp = (i / 3) ? 10'(stpc_pkg::GAP_LONG_CYC) : 10'(stpc_pkg::GAP_SHORT_CYC);
      `CHK("gap", 1'b1, (low_run >= gp && low_run <= gp + 10'h001))
      `CHK("end level", (i % 3) != 1, end_level)
      `CHK("burst", (i % 3 == 2) ? 10'(stpc_pkg::NLP_CYC) : 10'(stpc_pkg::DATA_HALF_BITS
        + ((i % 3) ? stpc_pkg::EOP_B_CYC : stpc_pkg::EOP_A_CYC)), high_run)
      @(posedge clk_sys);
      wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h0000_0000, 4'h1);
      repeat (3) @(posedge clk_sys);
      `CHK("drive off", 1'b0, tx10_drive)
    end
    $display("test patterns done");
    wr(stpc_pkg::ADDR_PATTERN_CTRL, 32'h0000_0013, 4'h1);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    l0 = tx10_line;
    @(negedge clk_sys);
    `CHK("tone", {1'b1, ~l0}, {tx10_drive, tx10_line})
    $display("test tone done");
    final_report();
  end
endmodule : packet_bist_pattern_control_tb_top
`default_nettype wire
